// file: logic/emmc_bus_mode_params.svh
// timing constants and numbers for the e-mmc bus mode and reset block
// Functional notes
// - Device starts in backward-compatible timing after power-up or any reset.
// - A high-speed switch request moves the device into the chosen timing mode.
// - Device accepts any clock up to 26 MHz, 52 MHz or 200 MHz per mode.
// - Backward-compatible mode launches command and data on the falling edge.
// - Dual data rate drives and samples all eight data lines on both edges.
// - Dual data rate keeps the command line on rising edges only.
// - Rising edge on the active-low reset pin starts the internal reset sequence.
// - Data lines are sampled on rising edges in every mode, and also on falling edges in dual data rate.
`ifndef EMMC_BUS_MODE_PARAMS_SVH
`define EMMC_BUS_MODE_PARAMS_SVH
`define CORE_CLK_MHZ 200
`define RESET_TO_CMD_WAIT_US 200
`define RESET_TO_CMD_CYCLES (`RESET_TO_CMD_WAIT_US * `CORE_CLK_MHZ)
`define CEIL_COMPAT_MHZ 8'h1A
`define CEIL_HIGH_SPEED_MHZ 8'h34
`define CEIL_HS200_MHZ 8'hC8
`define DAT_WIDTH 8
`endif

// file: logic/emmc_bus_mode_pkg.sv
// types shared by the e-mmc bus mode block
package emmc_bus_mode_pkg;
   typedef enum logic [1:0] {
      MODE_COMPAT = 2'b00,
      MODE_HIGH_SPEED = 2'b01,
      MODE_DDR = 2'b11,
      MODE_HS200 = 2'b10
   } bus_mode_e;
   typedef enum logic [0:0] {
      ST_READY = 1'b0,
      ST_RESET_SEQ = 1'b1
   } rst_state_e;
endpackage : emmc_bus_mode_pkg

// file: logic/emmc_bus_mode.sv
// bus timing mode control, edge steering and hardware reset sequencing
`timescale 1ns/1ps
`include "emmc_bus_mode_params.svh"
module emmc_bus_mode
   import emmc_bus_mode_pkg::*;
#(
   parameter int unsigned RESET_SEQ_CYCLES = `RESET_TO_CMD_CYCLES
) (
   input wire logic core_clk, // core clock, 200 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic switch_req, // one-cycle mode switch request, core domain
   input wire logic [1:0] switch_mode, // requested bus_mode_e
   input wire logic hw_rst_pin_n, // hardware reset pin from host
   output logic [1:0] bus_mode, // current mode, core domain
   output logic [7:0] clk_ceiling_mhz, // accepted clock ceiling for mode
   output logic reset_busy, // reset pin held low or internal reset sequence running
   output logic reset_start, // one-cycle pulse at reset pin release
   input wire logic bus_clk, // bus clock from host, link domain
   input wire logic cmd_i, // command pin input
   output logic cmd_o, // command pin output
   output logic cmd_oe_n, // command pin enable, low drives
   input wire logic [`DAT_WIDTH-1:0] dat_i, // data pins input
   output logic [`DAT_WIDTH-1:0] dat_o, // data pins output
   output logic dat_oe_n, // data pins enable, low drives
   input wire logic tx_cmd, // command bit to launch, link domain
   input wire logic tx_cmd_en, // drive command line
   input wire logic [`DAT_WIDTH-1:0] tx_dat, // data, rise half in ddr
   input wire logic [`DAT_WIDTH-1:0] tx_dat_fall, // data, fall half in ddr
   input wire logic tx_dat_en, // drive data lines
   output logic rx_cmd, // command bit sampled on rising edge
   output logic [`DAT_WIDTH-1:0] rx_dat_rise, // data sampled on rising edge
   output logic [`DAT_WIDTH-1:0] rx_dat_fall, // data sampled on falling edge
   output logic [1:0] link_mode // mode as seen in link domain
);

   // ---------------- core domain ----------------
   logic rpin_s1_q, rpin_s2_q, rpin_s3_q;
   rst_state_e rst_st_q;
   logic [31:0] seq_cnt_q;
   bus_mode_e mode_q;
   logic [7:0] ceil_q;
   logic pin_rise, pin_low;

   // syncs load the pin's idle level, so no false rise follows reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rpin_s1_q <= 1'b1;
         rpin_s2_q <= 1'b1;
         rpin_s3_q <= 1'b1;
      end else begin
         rpin_s1_q <= hw_rst_pin_n;
         rpin_s2_q <= rpin_s1_q;
         rpin_s3_q <= rpin_s2_q;
      end
   end

   assign pin_rise = rpin_s2_q & ~rpin_s3_q;
   assign pin_low = ~rpin_s2_q;

   // reset sequence: starts at the pin's release, not at its assertion
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_st_q <= ST_READY;
         seq_cnt_q <= 32'h0000_0000;
      end else begin
         case (rst_st_q)
            ST_READY: begin
               if (pin_rise) begin
                  rst_st_q <= ST_RESET_SEQ;
                  seq_cnt_q <= 32'h0000_0000;
               end
            end
            ST_RESET_SEQ: begin
               if (pin_low) begin
                  rst_st_q <= ST_READY;
               end else if (seq_cnt_q == 32'(RESET_SEQ_CYCLES - 1)) begin
                  rst_st_q <= ST_READY;
               end else begin
                  seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
               end
            end
            default: rst_st_q <= ST_READY;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_start <= 1'b0;
      end else begin
         reset_start <= pin_rise;
      end
   end

   assign reset_busy = (rst_st_q == ST_RESET_SEQ) | pin_low;

   // timing mode; any reset returns to compatible timing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_COMPAT;
      end else if (pin_low || pin_rise) begin
         mode_q <= MODE_COMPAT;
      end else if (switch_req && rst_st_q == ST_READY) begin
         mode_q <= bus_mode_e'(switch_mode);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ceil_q <= `CEIL_COMPAT_MHZ;
      end else begin
         case (mode_q)
            MODE_COMPAT: ceil_q <= `CEIL_COMPAT_MHZ;
            MODE_HIGH_SPEED: ceil_q <= `CEIL_HIGH_SPEED_MHZ;
            MODE_DDR: ceil_q <= `CEIL_HIGH_SPEED_MHZ;
            default: ceil_q <= `CEIL_HS200_MHZ;
         endcase
      end
   end

   assign bus_mode = mode_q;
   assign clk_ceiling_mhz = ceil_q;

   // ---------------- link domain ----------------
   // mode bits synchronised, taken only once two samples agree
   logic [1:0] lm_s1_q, lm_s2_q, lm_s3_q;
   bus_mode_e lmode_q;

   always_ff @(posedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         lm_s1_q <= 2'b00;
         lm_s2_q <= 2'b00;
         lm_s3_q <= 2'b00;
         lmode_q <= MODE_COMPAT;
      end else begin
         lm_s1_q <= mode_q;
         lm_s2_q <= lm_s1_q;
         lm_s3_q <= lm_s2_q;
         if (lm_s2_q == lm_s3_q) begin
            lmode_q <= bus_mode_e'(lm_s3_q);
         end
      end
   end

   assign link_mode = lmode_q;

   logic cmd_r_q, cmd_f_q, cmd_en_r_q, cmd_en_f_q;
   logic [`DAT_WIDTH-1:0] dat_r_q, dat_f_q;
   logic dat_en_r_q, dat_en_f_q;
   logic compat, ddr;

   assign compat = (lmode_q == MODE_COMPAT);
   assign ddr = (lmode_q == MODE_DDR);

   // rising-edge launch registers
   always_ff @(posedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r_q <= 1'b1;
         cmd_en_r_q <= 1'b0;
         dat_r_q <= 8'hFF;
         dat_en_r_q <= 1'b0;
      end else begin
         cmd_r_q <= tx_cmd;
         cmd_en_r_q <= tx_cmd_en;
         dat_r_q <= tx_dat;
         dat_en_r_q <= tx_dat_en;
      end
   end

   // falling-edge launch: compatible mode outputs, or ddr second half
   always_ff @(negedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_f_q <= 1'b1;
         cmd_en_f_q <= 1'b0;
         dat_f_q <= 8'hFF;
         dat_en_f_q <= 1'b0;
      end else begin
         cmd_f_q <= tx_cmd;
         cmd_en_f_q <= tx_cmd_en;
         dat_f_q <= ddr ? tx_dat_fall : tx_dat;
         dat_en_f_q <= ddr ? dat_en_r_q : tx_dat_en;
      end
   end

   always_comb begin
      if (compat) begin
         cmd_o = cmd_f_q;
         cmd_oe_n = ~cmd_en_f_q;
         dat_o = dat_f_q;
         dat_oe_n = ~dat_en_f_q;
      end else if (ddr) begin
         cmd_o = cmd_r_q;
         cmd_oe_n = ~cmd_en_r_q;
         dat_o = bus_clk ? dat_r_q : dat_f_q;
         dat_oe_n = ~dat_en_r_q;
      end else begin
         cmd_o = cmd_r_q;
         cmd_oe_n = ~cmd_en_r_q;
         dat_o = dat_r_q;
         dat_oe_n = ~dat_en_r_q;
      end
   end

   // sampling: pins belong to bus_clk, so no synchroniser here
   always_ff @(posedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cmd <= 1'b1;
         rx_dat_rise <= 8'hFF;
      end else begin
         rx_cmd <= cmd_i;
         rx_dat_rise <= dat_i;
      end
   end

   always_ff @(negedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_dat_fall <= 8'hFF;
      end else if (ddr) begin
         rx_dat_fall <= dat_i;
      end
   end

endmodule : emmc_bus_mode

// file: tb/emmc_host_model.sv
// host side model: link clock and pin levels
`timescale 1ns/1ps
module emmc_host_model (
   input wire logic run, // frame on
   output logic bus_clk, // link clock
   input wire logic cmd_o, // dev cmd
   input wire logic cmd_oe_n, // dev cmd enable
   input wire logic [7:0] dat_o, // dev data
   input wire logic dat_oe_n, // dev data enable
   output logic cmd_i, // cmd wire
   output logic [7:0] dat_i // data wire
);
   logic [8:0] drv_q = 9'h1FF;
   int seed = 32'hc0f3;
   initial begin
      bus_clk = 1'b0;
      #1.3;
      forever #6 bus_clk = run & ~bus_clk;
   end
   // new host levels after every edge, both edges for dual rate
   always @(bus_clk) drv_q <= #1 9'($random(seed));
   assign cmd_i = cmd_oe_n ? drv_q[8] : cmd_o;
   assign dat_i = dat_oe_n ? drv_q[7:0] : dat_o;
endmodule : emmc_host_model

// file: tb/emmc_bus_mode_checker.sv
// assertions on the bus mode and reset block ports
`timescale 1ns/1ps
module emmc_bus_mode_checker
   import emmc_bus_mode_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset
   input wire logic switch_req, // request
   input wire logic [1:0] switch_mode, // mode
   input wire logic hw_rst_pin_n, // pin
   input wire logic [1:0] bus_mode, // mode
   input wire logic [7:0] clk_ceiling_mhz, // ceiling
   input wire logic reset_busy, // busy
   input wire logic reset_start, // start
   input wire logic bus_clk, // link clock
   input wire logic cmd_o, // cmd
   input wire logic cmd_oe_n, // enable
   input wire logic tx_cmd, // cmd bit
   input wire logic [1:0] link_mode // link mode
);
   mode_take_a: assert property (
      @(posedge core_clk) disable iff (!rst_n) switch_req && !reset_busy
      |=> bus_mode == $past(switch_mode)) else $error("mode lost");
   ceiling_map_a: assert property (
      @(posedge core_clk) disable iff (!rst_n) clk_ceiling_mhz ==
      ($past(bus_mode) == MODE_HS200 ? 8'hC8 : $past(bus_mode) ==
      MODE_COMPAT ? 8'h1A : 8'h34)) else $error("ceiling");
   start_compat_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reset_start |-> bus_mode == MODE_COMPAT) else $error("not compat");
   start_pulse_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reset_start |=> !reset_start) else $error("start long");
   pin_busy_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !hw_rst_pin_n [*3] |-> reset_busy) else $error("not busy");
   rise_start_a: assert property (
      @(posedge core_clk) disable iff (!rst_n) !hw_rst_pin_n [*3] ##1
      hw_rst_pin_n [*2] |-> ##[0:4] reset_start) else $error("no start");
   compat_fall_a: assert property (
      @(negedge bus_clk) disable iff (!rst_n) (link_mode == MODE_COMPAT)
      [*2] |-> cmd_oe_n || cmd_o == $past(tx_cmd)) else $error("fall");
   cmd_rise_a: assert property (
      @(posedge bus_clk) disable iff (!rst_n) (link_mode != MODE_COMPAT)
      [*2] |-> cmd_oe_n || cmd_o == $past(tx_cmd)) else $error("rise");
endmodule : emmc_bus_mode_checker
bind emmc_bus_mode emmc_bus_mode_checker chk_u (.*);

// file: tb/testbench.sv
// self-checking bench for the bus mode and reset block
`timescale 1ns/1ps
`define CHECK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
   num_errors++; $display("unexpected at %0t: %s", $time, m); end end
module testbench;
   import emmc_bus_mode_pkg::*;
   localparam int unsigned SEQ = 20;
   logic core_clk = 1'b0, rst_n = 1'b0, switch_req = 1'b0, run = 1'b0;
   logic hw_rst_pin_n = 1'b1, tx_cmd = 1'b1, tx_cmd_en = 1'b0;
   logic tx_dat_en = 1'b0, bus_clk, cmd_i, cmd_o, cmd_oe_n, dat_oe_n;
   logic reset_busy, reset_start, rx_cmd;
   logic [1:0] switch_mode = 2'b00, bus_mode, link_mode, last_mode = 2'b00;
   logic [7:0] tx_dat = 8'hFF, tx_dat_fall = 8'hFF, dat_i, dat_o;
   logic [7:0] clk_ceiling_mhz, rx_dat_rise, rx_dat_fall;
   logic [1:0] exp_q[$];
   logic lchk = 1'b0, e, s_cmd, r_cmd, r_cen, r_den, f_cmd, f_cen, f_den;
   logic [7:0] s_dat, r_dat, f_dat;
   int num_errors = 0, n_checks = 0, seed = 32'hc0f3, i;
   bus_mode_e modes[4] =
      '{MODE_HS200, MODE_DDR, MODE_COMPAT, MODE_HIGH_SPEED};
   emmc_bus_mode #(.RESET_SEQ_CYCLES(SEQ)) dut_u (.*);
   emmc_host_model host_u (.*);
   initial forever #2.5 core_clk = ~core_clk;
   function automatic logic [7:0] exp_ceil(input logic [1:0] m);
      return m == MODE_HS200 ? 8'hC8 : (m == MODE_COMPAT ? 8'h1A : 8'h34);
   endfunction : exp_ceil
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic wait_idle();
      for (i = 0; i < 100 && reset_busy !== 1'b0; i++) tick(1);
      `CHECK(reset_busy, 1'b0, "busy")
      if (i == 100) print_verdict();
   endtask : wait_idle
   task automatic switch_to(input bus_mode_e m);
      switch_req = 1'b1;
      switch_mode = m;
      exp_q.push_back(m);
      tick(1);
      switch_req = 1'b0;
      tick(1);
      `CHECK(clk_ceiling_mhz, exp_ceil(m), "ceiling")
      run = 1'b1;
      for (i = 0; i < 200 && link_mode !== m; i++) tick(1);
      `CHECK(link_mode, m, "link mode")
      if (i == 200) print_verdict();
      repeat (2) @(posedge bus_clk);
      lchk = 1'b1;
      repeat (24) begin
         @(bus_clk);
         #1;
         {tx_cmd, tx_cmd_en, tx_dat_en, tx_dat, tx_dat_fall} =
            19'($random(seed));
      end
      lchk = 1'b0;
      run = 1'b0;
   endtask : switch_to
   // link monitor: notes launch values and pin levels at each edge
   always @(bus_clk) begin
      e = bus_clk;
      s_cmd = cmd_i;
      s_dat = dat_i;
      if (e) begin
         {r_cmd, r_cen, r_den, r_dat} = {tx_cmd, tx_cmd_en, tx_dat_en, tx_dat};
      end else begin
         {f_cmd, f_cen, f_den} = {tx_cmd, tx_cmd_en, tx_dat_en};
         f_dat = (link_mode == MODE_DDR) ? tx_dat_fall : tx_dat;
      end
      #2;
      if (lchk && e) begin
         `CHECK(rx_cmd, s_cmd, "cmd sample")
         `CHECK(rx_dat_rise, s_dat, "dat rise sample")
      end
      if (lchk && !e && link_mode == MODE_DDR) begin
         `CHECK(rx_dat_fall, s_dat, "dat fall sample")
      end
      if (lchk && link_mode == MODE_COMPAT) begin
         `CHECK({cmd_o, cmd_oe_n}, {f_cmd, !f_cen}, "compat cmd")
         `CHECK({dat_o, dat_oe_n}, {f_dat, !f_den}, "compat dat")
      end else if (lchk) begin
         `CHECK({cmd_o, cmd_oe_n}, {r_cmd, !r_cen}, "rise cmd")
         `CHECK({dat_o, dat_oe_n},
            {(link_mode == MODE_DDR && !e) ? f_dat : r_dat, !r_den},
            "launch dat")
      end
   end
   // every mode change seen must match the oldest note
   always @(posedge core_clk) begin
      #1;
      if (rst_n && bus_mode !== last_mode) begin
         `CHECK(bus_mode, exp_q.pop_front(), "mode change")
         last_mode = bus_mode;
      end
   end
   initial begin
      tick(6);
      rst_n = 1'b1;
      `CHECK(bus_mode, MODE_COMPAT, "reset mode")
      wait_idle();
      foreach (modes[k]) switch_to(modes[k]);
      exp_q.push_back(MODE_COMPAT);
      hw_rst_pin_n = 1'b0;
      tick(200);
      hw_rst_pin_n = 1'b1;
      for (i = 0; i < 10 && reset_start !== 1'b1; i++) tick(1);
      `CHECK(reset_start, 1'b1, "no start")
      if (i == 10) print_verdict();
      `CHECK(bus_mode, MODE_COMPAT, "pin mode")
      // request during the sequence must be ignored
      switch_req = 1'b1;
      switch_mode = MODE_DDR;
      tick(1);
      switch_req = 1'b0;
      tick(SEQ - 4);
      `CHECK(reset_busy, 1'b1, "short sequence")
      wait_idle();
      run = 1'b1;
      repeat (74) @(posedge bus_clk);
      run = 1'b0;
      tick(1);
      switch_to(MODE_DDR);
      print_verdict();
   end
endmodule : testbench
